/* include/rqhr_cfg.svh */
/*
  Offsets, field positions, reset values and timing counts of the receive
  queue readout. Assumes a 16-bit register space with byte addresses.
*/
`ifndef RQHR_CFG_SVH
`define RQHR_CFG_SVH

// ==========================================================
// Register offsets (byte addresses)
`define RQHR_OFS_RXC1 8'h74
`define RQHR_OFS_RXC2 8'h76
`define RQHR_OFS_FHST 8'h7C
`define RQHR_OFS_FHLN 8'h7E
`define RQHR_OFS_RXQC 8'h82
`define RQHR_OFS_RXDP 8'h86
`define RQHR_OFS_RTHR 8'h8C
`define RQHR_OFS_BTHR 8'h8E
`define RQHR_OFS_IEN 8'h90
`define RQHR_OFS_IST 8'h92
`define RQHR_OFS_FCTR 8'h9C
`define RQHR_OFS_DATA 8'hC0

// ==========================================================
// Field positions
`define RQHR_C1_BLOCK 0
`define RQHR_C1_FLOW 10
`define RQHR_QC_RELEASE 0
`define RQHR_QC_DMA 3
`define RQHR_QC_AUTODQ 4
`define RQHR_QC_FRMEN 5
`define RQHR_QC_BYTEN 6
`define RQHR_QC_TIMEN 7
`define RQHR_QC_IPOFS 9
`define RQHR_QC_FRMST 10
`define RQHR_QC_BYTST 11
`define RQHR_QC_TIMST 12
`define RQHR_DP_AUTOINC 14
`define RQHR_IRQ_RX 13

// ==========================================================
// Reset values, masks and sizes
`define RQHR_RST_WORD 16'h0000
`define RQHR_QC_WMASK 16'h02F8
`define RQHR_LEN_MASK 16'h0FFF
`define RQHR_MAX_DATA 16'h07D0
`define RQHR_HDR_WORDS 2

// ==========================================================
// Timing
`define RQHR_CLK_NS 10
`define RQHR_TICK_NS 1000
`define RQHR_TICK_CYC (`RQHR_TICK_NS / `RQHR_CLK_NS)

`endif

/* include/rqhr_pkg.sv */
/*
  Types of the receive queue readout: host bus pins, receive beats and
  the frame header update states. Assumes nothing beyond SystemVerilog.
*/
package rqhr_pkg;

  // ==========================================================
  // Host bus pins as sampled
  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic [7:0] addr;
    logic [15:0] wdata;
  } rqhr_bus_t;

  // ==========================================================
  // Receive beat: status, byte count, then packet words
  typedef struct packed {
    logic valid;
    logic last;
    logic [15:0] data;
  } rqhr_beat_t;

  // ==========================================================
  // Frame header register update, Gray along the path
  typedef enum logic [1:0] {
    HDR_IDLE = 2'b00,
    HDR_SHOWN = 2'b01,
    HDR_HALF = 2'b11
  } rqhr_hdr_t;

endpackage

/* hw/rqhr_rx_queue_host_readout.sv */
/*
  Receive queue of the controller and its host readout over the SRAM-like
  register bus. Assumes one clock mclk, receive beats from same-clock MAC
  logic, and bus pins from outside the clock domain.
*/
`timescale 1ns/100ps
`include "rqhr_cfg.svh"

// Function
// - Frame seen at offset 0 status, 2 byte count, 4 upward packet data.
// - Stored packet data keeps the trailing CRC bytes.
// - Packet data of one frame limited to 2000 bytes.
// - Big-endian mode swaps bytes of status and byte count words read at the data port.
// - Control one: bit 10 flow control, bit 0 receive enable.
// - Control two holds checksum and address filter settings.
// - Header status register shows head frame status.
// - Header length register shows 12-bit head frame byte count.
// - Queue control bit 3 starts host DMA access to queue data.
// - Bit 4 auto dequeue; bit 9 inserts two bytes before IP header.
// - Data pointer bit 14 auto-increments address on each data access but the dummy read.
// - Bit 7 and residence time over threshold raise interrupt, status 12.
// - Bit 6 and queued bytes over threshold raise interrupt, status 11.
// - Bit 5 and queued frames over threshold raise interrupt, status 10.
// - Frame counter upper byte reports frame total at interrupt clear.
// - Enable bit 13 gates receive interrupt held in status bit 13.
// - Writing ones to interrupt status clears those bits.
// - First DMA read item is dummy; host discards it.
// - Clearing receive interrupt updates the frame counter register.
// - Reading frame counter loads header status and length registers.
// - After both header reads the next frame header is loaded.
module rqhr_rx_queue_host_readout #(
  parameter int AW = 13,
  parameter int TICK_CYC = `RQHR_TICK_CYC
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // Host bus pins
  input wire rqhr_pkg::rqhr_bus_t busPins,
  input wire logic bigEndian,
  output logic [15:0] busRdata,
  output logic busOe,
  // Receive beats from the MAC
  input wire rqhr_pkg::rqhr_beat_t rxBeat,
  output logic rxReady,
  // Controls and interrupt
  output logic flowCtrlEn,
  output logic [15:0] rxControlTwo,
  output logic rxIrq
);

  localparam int DEPTH = 1 << AW;
  localparam int MAXW = `RQHR_HDR_WORDS + `RQHR_MAX_DATA / 2;

  // Tick counter is only 7 bits wide
  if (AW < 11 || AW > 16 || TICK_CYC < 1 || TICK_CYC > 128) begin : g_bad_param
    $error("rqhr: queue too small or tick invalid");
  end

  // ==========================================================
  // Helpers
  function automatic logic [AW-1:0] frameWords(input logic [15:0] len);
    logic [15:0] dw;
    dw = (len + 16'h0003) >> 2;
    frameWords = AW'(`RQHR_HDR_WORDS + 2 * int'(dw));
  endfunction

  function automatic logic [15:0] swapIf(input logic [15:0] w, input logic sw);
    swapIf = sw ? {w[7:0], w[15:8]} : w;
  endfunction

  function automatic logic [15:0] clampLen(input logic [15:0] n);
    clampLen = n > `RQHR_MAX_DATA ? `RQHR_MAX_DATA : n & `RQHR_LEN_MASK;
  endfunction

  // ==========================================================
  // Bus pin synchroniser and strobes
  rqhr_pkg::rqhr_bus_t busS1, busS2, busS3;
  logic beS1, beS2;
  always_ff @(posedge mclk) begin
    if (srst) begin
      busS1 <= '1;
      busS2 <= '1;
      busS3 <= '1;
      beS1 <= 1'b0;
      beS2 <= 1'b0;
    end else if (ce) begin
      busS1 <= busPins;
      busS2 <= busS1;
      busS3 <= busS2;
      beS1 <= bigEndian;
      beS2 <= beS1;
    end
  end

  logic rdAct, rdPrev, wrPrev, rdStart, wrEnd;
  logic [7:0] rdAddr, wrAddr;
  logic [15:0] wrData;
  assign rdAct = !busS2.csN && !busS2.rdN;
  assign rdPrev = !busS3.csN && !busS3.rdN;
  assign wrPrev = !busS3.csN && !busS3.wrN;
  assign rdStart = rdAct && !rdPrev;
  // Write taken at strobe end, data has settled by then
  assign wrEnd = wrPrev && !(!busS2.csN && !busS2.wrN);
  assign rdAddr = busS2.addr;
  assign wrAddr = busS3.addr;
  assign wrData = busS3.wdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = {a[7:1], 1'b0} == ofs;
  endfunction

  // ==========================================================
  // Software registers
  logic [15:0] rxc1, receive_queue, rxdp, rthr, bthr, ien, frmThr;
  logic [15:0] ist, fctrHi, hdrStatus, hdrLen;
  logic [AW-1:0] wrPtr, headPtr, hdrPtr, dataBase;
  logic [15:0] frameCnt, pendHdr, byteCnt, curLen, resTime;
  logic dmaFirst, frameOpen;
  logic [AW-1:0] frmLen;
  logic [6:0] tickCnt;

  logic clrRx, dataAcc, dataRd, release1, hdrRdSt, hdrRdLn;
  assign clrRx = wrEnd && hit(wrAddr, `RQHR_OFS_IST) && wrData[`RQHR_IRQ_RX];
  assign dataAcc = receive_queue[`RQHR_QC_DMA] && ((rdStart && hit(rdAddr, `RQHR_OFS_DATA))
    || (wrEnd && hit(wrAddr, `RQHR_OFS_DATA)));
  assign dataRd = rdStart && hit(rdAddr, `RQHR_OFS_DATA) && receive_queue[`RQHR_QC_DMA];
  assign hdrRdSt = rdStart && hit(rdAddr, `RQHR_OFS_FHST);
  assign hdrRdLn = rdStart && hit(rdAddr, `RQHR_OFS_FHLN);

  always_ff @(posedge mclk) begin
    if (srst) begin
      rxc1 <= `RQHR_RST_WORD;
      rxControlTwo <= `RQHR_RST_WORD;
      rthr <= `RQHR_RST_WORD;
      bthr <= `RQHR_RST_WORD;
      ien <= `RQHR_RST_WORD;
      frmThr <= `RQHR_RST_WORD;
    end else if (ce && wrEnd) begin
      if (hit(wrAddr, `RQHR_OFS_RXC1)) rxc1 <= wrData;
      if (hit(wrAddr, `RQHR_OFS_RXC2)) rxControlTwo <= wrData;
      if (hit(wrAddr, `RQHR_OFS_RTHR)) rthr <= wrData;
      if (hit(wrAddr, `RQHR_OFS_BTHR)) bthr <= wrData;
      if (hit(wrAddr, `RQHR_OFS_IEN)) ien <= wrData;
      if (hit(wrAddr, `RQHR_OFS_FCTR)) frmThr <= {8'h00, wrData[7:0]};
    end
  end

  // ==========================================================
  // Threshold events, sticky until the receive interrupt is cleared
  logic frmOver, bytOver, timOver;
  assign frmOver = receive_queue[`RQHR_QC_FRMEN] && frameCnt > frmThr;
  assign bytOver = receive_queue[`RQHR_QC_BYTEN] && byteCnt > bthr;
  assign timOver = receive_queue[`RQHR_QC_TIMEN] && resTime > rthr;

  logic dmaRise;
  always_ff @(posedge mclk) begin
    if (srst) begin
      receive_queue <= `RQHR_RST_WORD;
    end else if (ce) begin
      if (wrEnd && hit(wrAddr, `RQHR_OFS_RXQC)) begin
        receive_queue[9:0] <= 10'(wrData & `RQHR_QC_WMASK);
        receive_queue[`RQHR_QC_RELEASE] <= wrData[`RQHR_QC_RELEASE];
      end else begin
        receive_queue[`RQHR_QC_RELEASE] <= 1'b0;
      end
      // Event wins over a clear in the same cycle
      receive_queue[`RQHR_QC_FRMST] <= frmOver || (receive_queue[`RQHR_QC_FRMST] && !clrRx);
      receive_queue[`RQHR_QC_BYTST] <= bytOver || (receive_queue[`RQHR_QC_BYTST] && !clrRx);
      receive_queue[`RQHR_QC_TIMST] <= timOver || (receive_queue[`RQHR_QC_TIMST] && !clrRx);
    end
  end
  assign dmaRise = wrEnd && hit(wrAddr, `RQHR_OFS_RXQC) && wrData[`RQHR_QC_DMA]
    && !receive_queue[`RQHR_QC_DMA];

  always_ff @(posedge mclk) begin
    if (srst) begin
      ist <= `RQHR_RST_WORD;
    end else if (ce) begin
      ist[`RQHR_IRQ_RX] <= frmOver || bytOver || timOver
        || (ist[`RQHR_IRQ_RX] && !clrRx);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rxIrq <= 1'b0;
      flowCtrlEn <= 1'b0;
    end else if (ce) begin
      rxIrq <= ist[`RQHR_IRQ_RX] && ien[`RQHR_IRQ_RX];
      flowCtrlEn <= rxc1[`RQHR_C1_FLOW];
    end
  end

  // Frame total captured when software acknowledges the interrupt
  always_ff @(posedge mclk) begin
    if (srst) begin
      fctrHi <= `RQHR_RST_WORD;
    end else if (ce && clrRx) begin
      fctrHi <= frameCnt > 16'h00FF ? 16'h00FF : frameCnt;
    end
  end

  // ==========================================================
  // Queue memory and receive writer
  logic [15:0] mem [DEPTH];
  logic [AW-1:0] freeWords;
  logic acceptBeat, endFrame;
  logic [15:0] lenNow;
  assign freeWords = headPtr - wrPtr - AW'(1);
  assign acceptBeat = ce && rxBeat.valid && rxReady;
  assign endFrame = acceptBeat && rxBeat.last;
  // Count beat may itself close the frame; keeps writer and reader pointers in step
  assign lenNow = frmLen == AW'(1) ? clampLen(rxBeat.data) : curLen;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rxReady <= 1'b0;
    end else if (ce) begin
      // Whole worst-case frame reserved up front, so no stall mid-frame
      rxReady <= (frameOpen && !endFrame) || (rxc1[`RQHR_C1_BLOCK]
        && int'(freeWords) > MAXW + 1 && !endFrame);
    end
  end

  always_ff @(posedge mclk) begin
    if (acceptBeat && frmLen < AW'(MAXW)) begin
      if (frmLen == AW'(1)) begin
        mem[wrPtr + frmLen] <= clampLen(rxBeat.data);
      end else begin
        mem[wrPtr + frmLen] <= rxBeat.data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wrPtr <= '0;
      frmLen <= '0;
      frameOpen <= 1'b0;
      curLen <= `RQHR_RST_WORD;
    end else if (acceptBeat) begin
      if (frmLen == AW'(1)) begin
        curLen <= clampLen(rxBeat.data);
      end
      if (endFrame) begin
        // Next frame starts on a double-word boundary
        wrPtr <= wrPtr + frameWords(lenNow);
        frmLen <= '0;
        frameOpen <= 1'b0;
      end else begin
        frameOpen <= 1'b1;
        if (frmLen < AW'(MAXW)) frmLen <= frmLen + AW'(1);
      end
    end
  end

  // ==========================================================
  // Frame release, occupancy and residence time
  logic autoRel;
  assign autoRel = wrEnd && hit(wrAddr, `RQHR_OFS_RXQC) && receive_queue[`RQHR_QC_AUTODQ]
    && receive_queue[`RQHR_QC_DMA] && !wrData[`RQHR_QC_DMA];
  assign release1 = ce && frameCnt != 16'h0000 && (receive_queue[`RQHR_QC_RELEASE] || autoRel);

  logic [15:0] relLen;
  assign relLen = mem[headPtr + AW'(1)];

  always_ff @(posedge mclk) begin
    if (srst) begin
      headPtr <= '0;
      frameCnt <= `RQHR_RST_WORD;
      byteCnt <= `RQHR_RST_WORD;
    end else if (ce) begin
      if (release1) headPtr <= headPtr + frameWords(relLen);
      frameCnt <= frameCnt + 16'(endFrame) - 16'(release1);
      byteCnt <= byteCnt + (endFrame ? lenNow : 16'h0000) - (release1 ? relLen : 16'h0000);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || release1 || frameCnt == 16'h0000) begin
      tickCnt <= '0;
      resTime <= `RQHR_RST_WORD;
    end else if (ce) begin
      if (int'(tickCnt) >= TICK_CYC - 1) begin
        tickCnt <= '0;
        if (resTime != 16'hFFFF) resTime <= resTime + 16'h0001;
      end else begin
        tickCnt <= tickCnt + 7'h01;
      end
    end
  end

  // ==========================================================
  // Frame header registers
  rqhr_pkg::rqhr_hdr_t hdrSt;
  logic halfWasStatus, loadHdr;
  logic fctrRead;
  assign fctrRead = rdStart && hit(rdAddr, `RQHR_OFS_FCTR);
  assign loadHdr = ce && pendHdr != 16'h0000 && (
    (hdrSt == rqhr_pkg::HDR_IDLE && fctrRead)
    || (hdrSt == rqhr_pkg::HDR_HALF && ((halfWasStatus && hdrRdLn)
      || (!halfWasStatus && hdrRdSt))));

  always_ff @(posedge mclk) begin
    if (srst) begin
      hdrSt <= rqhr_pkg::HDR_IDLE;
      halfWasStatus <= 1'b0;
    end else if (ce) begin
      case (hdrSt)
        rqhr_pkg::HDR_IDLE: begin
          if (loadHdr) hdrSt <= rqhr_pkg::HDR_SHOWN;
        end
        rqhr_pkg::HDR_SHOWN: begin
          if (hdrRdSt || hdrRdLn) begin
            hdrSt <= rqhr_pkg::HDR_HALF;
            halfWasStatus <= hdrRdSt;
          end
        end
        rqhr_pkg::HDR_HALF: begin
          if (loadHdr) hdrSt <= rqhr_pkg::HDR_SHOWN;
          else if ((halfWasStatus && hdrRdLn) || (!halfWasStatus && hdrRdSt))
            hdrSt <= rqhr_pkg::HDR_IDLE;
        end
        default: hdrSt <= rqhr_pkg::HDR_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      hdrPtr <= '0;
      dataBase <= '0;
      pendHdr <= `RQHR_RST_WORD;
      hdrStatus <= `RQHR_RST_WORD;
      hdrLen <= `RQHR_RST_WORD;
    end else if (ce) begin
      pendHdr <= pendHdr + 16'(endFrame) - 16'(loadHdr);
      if (loadHdr) begin
        hdrStatus <= mem[hdrPtr];
        hdrLen <= mem[hdrPtr + AW'(1)] & `RQHR_LEN_MASK;
        dataBase <= hdrPtr;
        hdrPtr <= hdrPtr + frameWords(mem[hdrPtr + AW'(1)]);
      end
    end
  end

  // ==========================================================
  // Data pointer and DMA readout
  logic [9:0] effWord;
  logic [15:0] dataWord;
  assign effWord = rxdp[10:1];
  always_comb begin
    dataWord = 16'h0000;
    if (effWord < 10'd2) begin
      dataWord = swapIf(mem[dataBase + AW'(effWord)], beS2);
    end else if (!receive_queue[`RQHR_QC_IPOFS]) begin
      dataWord = mem[dataBase + AW'(effWord)];
    end else if (effWord != 10'd2) begin
      dataWord = mem[dataBase + AW'(effWord - 10'd1)];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rxdp <= `RQHR_RST_WORD;
      dmaFirst <= 1'b0;
    end else if (ce) begin
      if (dmaRise) dmaFirst <= 1'b1;
      else if (dataRd) dmaFirst <= 1'b0;
      if (wrEnd && hit(wrAddr, `RQHR_OFS_RXDP)) begin
        rxdp <= wrData & 16'h47FF;
      end else if (dataAcc && !(dataRd && dmaFirst) && rxdp[`RQHR_DP_AUTOINC]) begin
        rxdp[10:0] <= rxdp[10:0] + 11'h002;
      end
    end
  end

  // ==========================================================
  // Read data and drive
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    case ({rdAddr[7:1], 1'b0})
      `RQHR_OFS_RXC1: next_rdata = rxc1;
      `RQHR_OFS_RXC2: next_rdata = rxControlTwo;
      `RQHR_OFS_FHST: next_rdata = hdrStatus;
      `RQHR_OFS_FHLN: next_rdata = hdrLen;
      `RQHR_OFS_RXQC: next_rdata = receive_queue;
      `RQHR_OFS_RXDP: next_rdata = rxdp;
      `RQHR_OFS_RTHR: next_rdata = rthr;
      `RQHR_OFS_BTHR: next_rdata = bthr;
      `RQHR_OFS_IEN: next_rdata = ien;
      `RQHR_OFS_IST: next_rdata = ist;
      `RQHR_OFS_FCTR: next_rdata = {fctrHi[7:0], frmThr[7:0]};
      `RQHR_OFS_DATA: next_rdata = (dmaFirst || !receive_queue[`RQHR_QC_DMA]) ? 16'h0000 : dataWord;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      busRdata <= 16'h0000;
      busOe <= 1'b0;
    end else if (ce) begin
      if (rdStart) busRdata <= next_rdata;
      busOe <= rdAct;
    end
  end

  // ==========================================================
  // Checks
  sequence s_dummy_read;
    ce && dataRd && dmaFirst;
  endsequence
  sequence s_second_hdr_read;
    ce && hdrSt == rqhr_pkg::HDR_HALF && pendHdr != 16'h0000
      && ((halfWasStatus && hdrRdLn) || (!halfWasStatus && hdrRdSt));
  endsequence

  property p_irq_gate;
    @(posedge mclk) disable iff (srst) rxIrq |-> $past(ist[13] && ien[13]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");

  property p_sticky;
    @(posedge mclk) disable iff (srst) $fell(ist[13]) |-> $past(clrRx && ce);
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq status lost");

  property p_frm_thr;
    @(posedge mclk) disable iff (srst) ce && frmOver |=> receive_queue[10] && ist[13];
  endproperty
  a_frm_thr: assert property (p_frm_thr) else $error("frame threshold missed");

  property p_count_latch;
    @(posedge mclk) disable iff (srst)
      ce && clrRx && frameCnt < 16'h0100 |=> fctrHi == $past(frameCnt);
  endproperty
  a_count_latch: assert property (p_count_latch) else $error("count not updated");

  property p_hdr_load;
    @(posedge mclk) disable iff (srst)
      ce && hdrSt == rqhr_pkg::HDR_IDLE && fctrRead && pendHdr != 16'h0000
      |=> hdrSt == rqhr_pkg::HDR_SHOWN && hdrLen == (mem[dataBase + AW'(1)] & 16'h0FFF);
  endproperty
  a_hdr_load: assert property (p_hdr_load) else $error("header not loaded");

  property p_next_hdr;
    @(posedge mclk) disable iff (srst)
      s_second_hdr_read |=> dataBase == $past(hdrPtr) ##1 hdrSt != rqhr_pkg::HDR_IDLE;
  endproperty
  a_next_hdr: assert property (p_next_hdr) else $error("next header not loaded");

  property p_dummy;
    @(posedge mclk) disable iff (srst)
      s_dummy_read |=> busRdata == 16'h0000 && rxdp == $past(rxdp) && !dmaFirst;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy item wrong");

  property p_autoinc;
    @(posedge mclk) disable iff (srst)
      ce && dataRd && !dmaFirst && rxdp[14] |=> rxdp[10:0] == $past(rxdp[10:0]) + 11'h002;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("pointer not advanced");

  property p_max_len;
    @(posedge mclk) disable iff (srst) hdrLen <= 16'h07D0 && curLen <= 16'h07D0;
  endproperty
  a_max_len: assert property (p_max_len) else $error("frame over 2000 bytes");

endmodule

/* testbench/rqhr_host_model.sv */
/*
  Host processor model on the SRAM-like register bus of the receive queue.
  Assumes the readout synchronises the strobes in two or three stages.
*/
`timescale 1ns/100ps
module rqhr_host_model (
  // Clock
  input wire logic mclk,
  // Bus pins and read data
  output rqhr_pkg::rqhr_bus_t busPins,
  input wire logic [15:0] busRdata,
  // Kept read results
  output logic rdStrobe,
  output logic [15:0] rdValue
);
  // ==========================================================
  // Idle bus
  initial begin
    busPins = '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: 8'h00, wdata: 16'h0000};
    rdStrobe = 1'b0;
    rdValue = 16'h0000;
  end

  // ==========================================================
  // One access: strobe low 8 cycles, address and data held 5 more
  task automatic regAccess(input logic wr, input logic [7:0] a, input logic [15:0] d,
                           input logic keep);
    @(posedge mclk);
    busPins.addr <= a;
    busPins.wdata <= d;
    busPins.csN <= 1'b0;
    busPins.rdN <= wr;
    busPins.wrN <= ~wr;
    repeat (8) @(posedge mclk);
    rdValue <= busRdata;
    rdStrobe <= keep & ~wr;
    busPins.csN <= 1'b1;
    busPins.rdN <= 1'b1;
    busPins.wrN <= 1'b1;
    @(posedge mclk);
    rdStrobe <= 1'b0;
    repeat (4) @(posedge mclk);
    // Released lines flip so stale values cannot pass for driven ones
    busPins.addr <= ~a;
    busPins.wdata <= ~d;
    repeat (2) @(posedge mclk);
  endtask
endmodule

/* testbench/testbench.sv */
/*
  Self-checking bench of the receive queue readout: host model on the bus,
  beat source on the receive side. Assumes TICK_CYC set to 4 cycles.
*/
`timescale 1ns/100ps
`include "rqhr_cfg.svh"
module testbench;
  // ==========================================================
  // Stimulus and observed signals
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic bigEndian = 1'b1;
  logic ce = 1'b1;
  rqhr_pkg::rqhr_beat_t rxBeat = '0;
  rqhr_pkg::rqhr_bus_t busPins;
  logic [15:0] busRdata, rdValue, rxControlTwo, st1, st2;
  logic [15:0] seed = 16'h0012;
  logic rdStrobe, rxReady, flowCtrlEn, rxIrq, busOe;
  logic [15:0] dq [$];
  logic [15:0] expQ [$];
  int failCount = 0;
  int nChecks = 0;

  always #5 mclk = ~mclk;

  rqhr_rx_queue_host_readout #(.TICK_CYC(4)) uut (
    .mclk(mclk), .srst(srst), .ce(ce), .busPins(busPins), .bigEndian(bigEndian),
    .busRdata(busRdata), .busOe(busOe), .rxBeat(rxBeat), .rxReady(rxReady),
    .flowCtrlEn(flowCtrlEn), .rxControlTwo(rxControlTwo), .rxIrq(rxIrq));
  rqhr_host_model host (.mclk(mclk), .busPins(busPins), .busRdata(busRdata),
    .rdStrobe(rdStrobe), .rdValue(rdValue));

  // ==========================================================
  // Helpers
  function automatic logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic testDone();
    repeat (3) @(posedge mclk);
    if (expQ.size() != 0) failCount++;
    $display("checks %0d, mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    host.regAccess(1'b0, a, 16'h0000, 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.regAccess(1'b1, a, d, 1'b0);
  endtask

  task automatic sendFrame(input logic [15:0] st, input logic [15:0] cnt);
    int n;
    logic [15:0] w;
    n = 0;
    @(posedge mclk);
    while (rxReady !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n == 100) begin
      failCount++;
      testDone();
    end
    rxBeat <= '{valid: 1'b1, last: 1'b0, data: st};
    @(posedge mclk);
    rxBeat.data <= cnt;
    for (int i = 0; i < (cnt + 1) / 2; i++) begin
      @(posedge mclk);
      w = xs();
      dq.push_back(w);
      rxBeat.data <= w;
      rxBeat.last <= (i == (cnt + 1) / 2 - 1);
    end
    @(posedge mclk);
    rxBeat <= '0;
    repeat (10) @(posedge mclk);
  endtask

  // ==========================================================
  // Result watcher: oldest expectation against each kept read
  always @(posedge mclk) begin
    if (rdStrobe) begin
      if (expQ.size() > 0) chk(expQ.pop_front(), rdValue);
      else failCount++;
      // Drive enable still up one cycle after the strobe is released
      chk(16'h0001, {15'h0000, busOe});
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd(`RQHR_OFS_RXC1, 16'h0000);
    rd(8'h00, 16'h0000);
    wr(`RQHR_OFS_RXC1, 16'h0401);
    wr(`RQHR_OFS_RXC2, 16'h00FF);
    rd(`RQHR_OFS_RXC1, 16'h0401);
    chk(16'h0001, {15'h0000, flowCtrlEn});
    chk(16'h00FF, rxControlTwo);
    st1 = xs();
    st2 = xs();
    sendFrame(st1, 16'h0006);
    // Threshold equal to the frame total must not fire
    wr(`RQHR_OFS_FCTR, 16'h0001);
    wr(`RQHR_OFS_RXQC, 16'h0020);
    rd(`RQHR_OFS_RXQC, 16'h0020);
    sendFrame(st2, 16'h000A);
    rd(`RQHR_OFS_IST, 16'h2000);
    chk(16'h0000, {15'h0000, rxIrq});
    wr(`RQHR_OFS_IEN, 16'h2000);
    chk(16'h0001, {15'h0000, rxIrq});
    wr(`RQHR_OFS_RXQC, 16'h0000);
    rd(`RQHR_OFS_RXQC, 16'h0400);
    wr(`RQHR_OFS_IST, 16'hFFFF);
    rd(`RQHR_OFS_IST, 16'h0000);
    chk(16'h0000, {15'h0000, rxIrq});
    rd(`RQHR_OFS_RXQC, 16'h0000);
    rd(`RQHR_OFS_FCTR, 16'h0201);
    rd(`RQHR_OFS_FHST, st1);
    // DMA of the head frame, big-endian status word
    wr(`RQHR_OFS_RXQC, 16'h0008);
    wr(`RQHR_OFS_RXDP, 16'h4000);
    rd(`RQHR_OFS_DATA, 16'h0000);
    rd(`RQHR_OFS_DATA, {st1[7:0], st1[15:8]});
    // Little-endian host sees the count word unswapped
    bigEndian <= 1'b0;
    rd(`RQHR_OFS_DATA, 16'h0006);
    for (int i = 0; i < 3; i++) rd(`RQHR_OFS_DATA, dq[i]);
    host.regAccess(1'b0, `RQHR_OFS_DATA, 16'h0000, 1'b0);
    rd(`RQHR_OFS_FHLN, 16'h0006);
    rd(`RQHR_OFS_FHST, st2);
    wr(`RQHR_OFS_RXQC, 16'h0001);
    // Second frame with the two-byte IP offset inserted at offset 4
    wr(`RQHR_OFS_RXQC, 16'h0208);
    wr(`RQHR_OFS_RXDP, 16'h4004);
    rd(`RQHR_OFS_DATA, 16'h0000);
    rd(`RQHR_OFS_DATA, 16'h0000);
    rd(`RQHR_OFS_DATA, dq[3]);
    // Byte and residence thresholds on the remaining frame
    wr(`RQHR_OFS_RTHR, 16'h0001);
    wr(`RQHR_OFS_BTHR, 16'h0000);
    wr(`RQHR_OFS_RXQC, 16'h00C0);
    repeat (6) @(posedge mclk);
    // Frozen core must keep every flag and timer
    ce <= 1'b0;
    repeat (8) @(posedge mclk);
    ce <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(`RQHR_OFS_RXQC, 16'h18C0);
    rd(`RQHR_OFS_IST, 16'h2000);
    chk(16'h0001, {15'h0000, rxIrq});
    wr(`RQHR_OFS_RXQC, 16'h0000);
    wr(`RQHR_OFS_IST, 16'hFFFF);
    rd(`RQHR_OFS_RXQC, 16'h0000);
    chk(16'h0000, {15'h0000, rxIrq});
    testDone();
  end
endmodule
